// File: src/aecr_regs.vh
// Register offsets, field positions and reset values of the error block
`ifndef AECR_REGS_VH
`define AECR_REGS_VH

`define AECR_CORR_STATUS_OFS 12'h110
`define AECR_CORR_MASK_OFS 12'h114
`define AECR_ERR_CTRL_OFS 12'h118
`define AECR_HDR_LOG0_OFS 12'h11c
`define AECR_HDR_LOG1_OFS 12'h120
`define AECR_HDR_LOG2_OFS 12'h124
`define AECR_HDR_LOG3_OFS 12'h128

`define AECR_RECEIVER_FAULT_BIT 0
`define AECR_CORRUPT_PACKET_BIT 6
`define AECR_CORRUPT_LINK_PACKET_BIT 7
`define AECR_REPLAY_COUNT_WRAP_BIT 8
`define AECR_REPLAY_TIMER_EXPIRY_BIT 12
`define AECR_ADVISORY_NONFATAL_BIT 13

`define AECR_FIRST_ERROR_INDEX_LSB 0
`define AECR_FIRST_ERROR_INDEX_MSB 4
`define AECR_E2E_CRC_GEN_CAPABLE_BIT 5
`define AECR_E2E_CRC_GEN_ENABLE_BIT 6
`define AECR_E2E_CRC_CHECK_CAPABLE_BIT 7
`define AECR_E2E_CRC_CHECK_ENABLE_BIT 8

`define AECR_CORR_STATUS_RESET 32'h0000_0000
`define AECR_CORR_MASK_RESET 32'h0000_2000
`define AECR_FIRST_ERROR_INDEX_RESET 5'h00
`define AECR_E2E_CRC_GEN_CAPABLE_RESET 1'h1
`define AECR_E2E_CRC_GEN_ENABLE_RESET 1'h0
`define AECR_E2E_CRC_CHECK_CAPABLE_RESET 1'h1
`define AECR_E2E_CRC_CHECK_ENABLE_RESET 1'h0
`define AECR_HDR_LOG_RESET 32'h0000_0000

`endif

// File: src/aecr_hdr_log.v
// Four-doubleword sticky header log with registered read port
`timescale 1ns/1ns
`include "aecr_regs.vh"

module aecr_hdr_log #(
	parameter DW = 32,
	parameter DEPTH = 4,
	parameter AW = 2
) (
	input wire clk,
	input wire rst,
	input wire wr_en,
	input wire [DW*DEPTH-1:0] wr_data,
	input wire rd_en,
	input wire rd_hit,
	input wire [AW-1:0] rd_addr,
	input wire [DW-1:0] alt_data,
	output reg [DW-1:0] rd_data
);

	wire [DW-1:0] word [0:DEPTH-1];
	genvar i;

	// Whole header is written at once; only a fundamental reset clears it
	generate
		for (i = 0; i < DEPTH; i = i + 1) begin : g_word
			reg [DW-1:0] mem_reg;
			always @(posedge clk) begin
				if (rst) begin
					mem_reg <= `AECR_HDR_LOG_RESET;
				end else if (wr_en) begin
					mem_reg <= wr_data[i*DW +: DW];
				end
			end
			assign word[i] = mem_reg;
		end
	endgenerate

	// Read data stand only in the cycle after the read strobe
	always @(posedge clk) begin
		if (rst) begin
			rd_data <= {DW{1'b0}};
		end else if (rd_en && rd_hit) begin
			rd_data <= word[rd_addr];
		end else if (rd_en) begin
			rd_data <= alt_data;
		end else begin
			rd_data <= {DW{1'b0}};
		end
	end

endmodule

// File: src/aecr_top.v
// Correctable error status, mask and error control registers
`timescale 1ns/1ns
`include "aecr_regs.vh"

// Overview of operation
// - Receiver fault event sets status bit 0
// - Corrupt packet event sets status bit 6
// - Corrupt link packet event sets bit 7
// - Replay count wrap sets status bit 8
// - Replay timer expiry sets status bit 12
// - Advisory non-fatal event sets bit 13
// - Set mask bit suppresses report to root
// - Advisory mask resets one, others zero
// - Bits 4:0 hold sticky first error index
// - Gen capable bit 5, resets one, lockable
// - Append end-to-end CRC while bit 6 set
// - Check capable bit 7 resets to one
// - Check end-to-end CRC while bit 8 set
// - Capture first error header, four words
module aecr_top #(
	parameter AW = 12,
	parameter DW = 32,
	parameter IDX_W = 5,
	parameter HDR_WORDS = 4
) (
	input wire REF_CLK,
	input wire RST,
	input wire HOT_RST,
	input wire [AW-1:0] REG_ADDR,
	input wire [DW-1:0] REG_WDATA,
	input wire REG_WR,
	input wire REG_RD,
	output wire [DW-1:0] REG_RDATA,
	input wire REG_LOCK,
	input wire RECEIVER_FAULT,
	input wire CORRUPT_PACKET_FLAG,
	input wire CORRUPT_LINK_PACKET_FLAG,
	input wire REPLAY_COUNT_WRAP,
	input wire REPLAY_TIMER_EXPIRY,
	input wire ADVISORY_NONFATAL,
	input wire UNCORR_REPORT,
	input wire [IDX_W-1:0] UNCORR_INDEX,
	input wire [DW*HDR_WORDS-1:0] UNCORR_HEADER,
	input wire UNCORR_RELEASE,
	output reg CORR_REPORT,
	output reg CORR_PENDING,
	output wire E2E_CRC_GEN_EN,
	output wire E2E_CRC_CHECK_EN
);

	localparam NEV = 6;

	// Bit position of each event in the status and mask registers
	localparam [NEV*5-1:0] EV_POS = {
		5'd`AECR_ADVISORY_NONFATAL_BIT,
		5'd`AECR_REPLAY_TIMER_EXPIRY_BIT,
		5'd`AECR_REPLAY_COUNT_WRAP_BIT,
		5'd`AECR_CORRUPT_LINK_PACKET_BIT,
		5'd`AECR_CORRUPT_PACKET_BIT,
		5'd`AECR_RECEIVER_FAULT_BIT
	};

	// Reset images of the packed status and mask bits, cut from the
	// register-wide reset words so the two cannot drift apart
	localparam [DW-1:0] STATUS_RST_WORD = `AECR_CORR_STATUS_RESET;
	localparam [DW-1:0] MASK_RST_WORD = `AECR_CORR_MASK_RESET;
	localparam [IDX_W-1:0] INDEX_RST = `AECR_FIRST_ERROR_INDEX_RESET;
	localparam [NEV-1:0] STATUS_RST = {
		STATUS_RST_WORD[`AECR_ADVISORY_NONFATAL_BIT],
		STATUS_RST_WORD[`AECR_REPLAY_TIMER_EXPIRY_BIT],
		STATUS_RST_WORD[`AECR_REPLAY_COUNT_WRAP_BIT],
		STATUS_RST_WORD[`AECR_CORRUPT_LINK_PACKET_BIT],
		STATUS_RST_WORD[`AECR_CORRUPT_PACKET_BIT],
		STATUS_RST_WORD[`AECR_RECEIVER_FAULT_BIT]
	};
	localparam [NEV-1:0] MASK_RST = {
		MASK_RST_WORD[`AECR_ADVISORY_NONFATAL_BIT],
		MASK_RST_WORD[`AECR_REPLAY_TIMER_EXPIRY_BIT],
		MASK_RST_WORD[`AECR_REPLAY_COUNT_WRAP_BIT],
		MASK_RST_WORD[`AECR_CORRUPT_LINK_PACKET_BIT],
		MASK_RST_WORD[`AECR_CORRUPT_PACKET_BIT],
		MASK_RST_WORD[`AECR_RECEIVER_FAULT_BIT]
	};

	reg [NEV-1:0] status_reg;
	reg [NEV-1:0] mask_reg;
	reg [IDX_W-1:0] first_index_reg;
	reg gen_capable_reg;
	reg gen_enable_reg;
	reg check_capable_reg;
	reg check_enable_reg;
	reg log_armed_reg;

	reg [NEV-1:0] status_next;
	reg [NEV-1:0] mask_next;
	reg [IDX_W-1:0] first_index_next;
	reg gen_capable_next;
	reg gen_enable_next;
	reg check_capable_next;
	reg check_enable_next;
	reg log_armed_next;
	reg report_next;
	reg pending_next;

	wire [NEV-1:0] ev;
	wire [DW-1:0] status_word;
	wire [DW-1:0] mask_word;
	wire [DW-1:0] ctrl_word;
	wire hit_status;
	wire hit_mask;
	wire hit_ctrl;
	wire hit_log;
	reg [1:0] log_index;
	wire capture;
	reg [DW-1:0] csr_rdata;

	assign ev[0] = RECEIVER_FAULT;
	assign ev[1] = CORRUPT_PACKET_FLAG;
	assign ev[2] = CORRUPT_LINK_PACKET_FLAG;
	assign ev[3] = REPLAY_COUNT_WRAP;
	assign ev[4] = REPLAY_TIMER_EXPIRY;
	assign ev[5] = ADVISORY_NONFATAL;

	// Address decode
	assign hit_status = (REG_ADDR == `AECR_CORR_STATUS_OFS);
	assign hit_mask = (REG_ADDR == `AECR_CORR_MASK_OFS);
	assign hit_ctrl = (REG_ADDR == `AECR_ERR_CTRL_OFS);
	assign hit_log = (REG_ADDR == `AECR_HDR_LOG0_OFS) ||
		(REG_ADDR == `AECR_HDR_LOG1_OFS) ||
		(REG_ADDR == `AECR_HDR_LOG2_OFS) ||
		(REG_ADDR == `AECR_HDR_LOG3_OFS);

	// Header log word selected by the read address
	always @* begin
		if (REG_ADDR == `AECR_HDR_LOG1_OFS) begin
			log_index = 2'h1;
		end else if (REG_ADDR == `AECR_HDR_LOG2_OFS) begin
			log_index = 2'h2;
		end else if (REG_ADDR == `AECR_HDR_LOG3_OFS) begin
			log_index = 2'h3;
		end else begin
			log_index = 2'h0;
		end
	end

	// Spread the packed event bits to their register positions
	genvar g;
	generate
		for (g = 0; g < DW; g = g + 1) begin : g_word
			if (g == `AECR_RECEIVER_FAULT_BIT) begin : g_b0
				assign status_word[g] = status_reg[0];
				assign mask_word[g] = mask_reg[0];
			end else if (g == `AECR_CORRUPT_PACKET_BIT) begin : g_b6
				assign status_word[g] = status_reg[1];
				assign mask_word[g] = mask_reg[1];
			end else if (g == `AECR_CORRUPT_LINK_PACKET_BIT) begin : g_b7
				assign status_word[g] = status_reg[2];
				assign mask_word[g] = mask_reg[2];
			end else if (g == `AECR_REPLAY_COUNT_WRAP_BIT) begin : g_b8
				assign status_word[g] = status_reg[3];
				assign mask_word[g] = mask_reg[3];
			end else if (g == `AECR_REPLAY_TIMER_EXPIRY_BIT) begin : g_b12
				assign status_word[g] = status_reg[4];
				assign mask_word[g] = mask_reg[4];
			end else if (g == `AECR_ADVISORY_NONFATAL_BIT) begin : g_b13
				assign status_word[g] = status_reg[5];
				assign mask_word[g] = mask_reg[5];
			end else begin : g_rsvd
				assign status_word[g] = 1'b0;
				assign mask_word[g] = 1'b0;
			end
		end
	endgenerate

	assign ctrl_word = {
		{(DW - 9){1'b0}},
		check_enable_reg,
		check_capable_reg,
		gen_enable_reg,
		gen_capable_reg,
		first_index_reg
	};

	// First uncorrectable error is logged only while the log is armed
	assign capture = UNCORR_REPORT && log_armed_reg;

	// Next-state logic for status, mask and control
	integer k;
	always @* begin
		status_next = status_reg;
		mask_next = mask_reg;
		first_index_next = first_index_reg;
		gen_capable_next = gen_capable_reg;
		gen_enable_next = gen_enable_reg;
		check_capable_next = check_capable_reg;
		check_enable_next = check_enable_reg;
		log_armed_next = log_armed_reg;
		report_next = 1'b0;
		for (k = 0; k < NEV; k = k + 1) begin
			// Write one clears; a same-cycle event sets it again
			if (REG_WR && hit_status && REG_WDATA[EV_POS[k*5 +: 5]]) begin
				status_next[k] = 1'b0;
			end
			if (ev[k]) begin
				status_next[k] = 1'b1;
			end
			if (ev[k] && !mask_reg[k]) begin
				report_next = 1'b1;
			end
			if (REG_WR && hit_mask) begin
				mask_next[k] = REG_WDATA[EV_POS[k*5 +: 5]];
			end
		end
		if (REG_WR && hit_ctrl) begin
			// Capable bits only change while the lock is open
			if (!REG_LOCK) begin
				gen_capable_next =
					REG_WDATA[`AECR_E2E_CRC_GEN_CAPABLE_BIT];
				check_capable_next =
					REG_WDATA[`AECR_E2E_CRC_CHECK_CAPABLE_BIT];
			end
			gen_enable_next = REG_WDATA[`AECR_E2E_CRC_GEN_ENABLE_BIT];
			check_enable_next =
				REG_WDATA[`AECR_E2E_CRC_CHECK_ENABLE_BIT];
		end
		// Release re-arms capture; a report in the same cycle is logged only if already armed
		if (UNCORR_RELEASE) begin
			log_armed_next = 1'b1;
		end
		if (capture) begin
			first_index_next = UNCORR_INDEX;
			log_armed_next = 1'b0;
		end
		pending_next = |(status_next & ~mask_next);
	end

	// Sticky fields: cleared only by the fundamental reset
	always @(posedge REF_CLK) begin
		if (RST) begin
			status_reg <= STATUS_RST;
			mask_reg <= MASK_RST;
			first_index_reg <= INDEX_RST;
			gen_enable_reg <= `AECR_E2E_CRC_GEN_ENABLE_RESET;
			check_enable_reg <= `AECR_E2E_CRC_CHECK_ENABLE_RESET;
			log_armed_reg <= 1'b1;
		end else begin
			status_reg <= status_next;
			mask_reg <= mask_next;
			first_index_reg <= first_index_next;
			gen_enable_reg <= gen_enable_next;
			check_enable_reg <= check_enable_next;
			log_armed_reg <= log_armed_next;
		end
	end

	// Non-sticky fields: also return to defaults on a hot reset
	always @(posedge REF_CLK) begin
		if (RST || HOT_RST) begin
			gen_capable_reg <= `AECR_E2E_CRC_GEN_CAPABLE_RESET;
			check_capable_reg <= `AECR_E2E_CRC_CHECK_CAPABLE_RESET;
			CORR_REPORT <= 1'b0;
			CORR_PENDING <= 1'b0;
		end else begin
			gen_capable_reg <= gen_capable_next;
			check_capable_reg <= check_capable_next;
			CORR_REPORT <= report_next;
			CORR_PENDING <= pending_next;
		end
	end

	assign E2E_CRC_GEN_EN = gen_enable_reg;
	assign E2E_CRC_CHECK_EN = check_enable_reg;

	// Register read mux; unmapped addresses read zero
	always @* begin
		if (hit_status) begin
			csr_rdata = status_word;
		end else if (hit_mask) begin
			csr_rdata = mask_word;
		end else if (hit_ctrl) begin
			csr_rdata = ctrl_word;
		end else begin
			csr_rdata = {DW{1'b0}};
		end
	end

	aecr_hdr_log #(
		.DW(DW),
		.DEPTH(HDR_WORDS),
		.AW(2)
	) u_hdr_log (
		.clk(REF_CLK),
		.rst(RST),
		.wr_en(capture),
		.wr_data(UNCORR_HEADER),
		.rd_en(REG_RD),
		.rd_hit(hit_log),
		.rd_addr(log_index),
		.alt_data(csr_rdata),
		.rd_data(REG_RDATA)
	);

endmodule

// File: sim/aecr_monitor.sv
// Checker watching the ports of the error register block
`timescale 1ns/1ns
module aecr_monitor (
	input wire REF_CLK,
	input wire RST,
	input wire HOT_RST,
	input wire [11:0] REG_ADDR,
	input wire [31:0] REG_WDATA,
	input wire REG_WR,
	input wire REG_RD,
	input wire [31:0] REG_RDATA,
	input wire RECEIVER_FAULT,
	input wire CORRUPT_PACKET_FLAG,
	input wire CORRUPT_LINK_PACKET_FLAG,
	input wire REPLAY_COUNT_WRAP,
	input wire REPLAY_TIMER_EXPIRY,
	input wire ADVISORY_NONFATAL,
	input wire CORR_REPORT,
	input wire CORR_PENDING,
	input wire E2E_CRC_GEN_EN,
	input wire E2E_CRC_CHECK_EN
);
	wire ev = RECEIVER_FAULT | CORRUPT_PACKET_FLAG | CORRUPT_LINK_PACKET_FLAG
		| REPLAY_COUNT_WRAP | REPLAY_TIMER_EXPIRY | ADVISORY_NONFATAL;
	wire cw = REG_WR && REG_ADDR == 12'h118;
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (RST);
	chk_rd_idle: assert property (
		!REG_RD |=> REG_RDATA == 32'h0) else $error("read data not idle");
	chk_status_rsv: assert property (
		REG_RD && REG_ADDR == 12'h110 |=> (REG_RDATA & 32'hffffce3e) == 0)
		else $error("status reserved bits set");
	chk_mask_rsv: assert property (
		REG_RD && REG_ADDR == 12'h114 |=> (REG_RDATA & 32'hffffce3e) == 0)
		else $error("mask reserved bits set");
	chk_ctrl_rsv: assert property (
		REG_RD && REG_ADDR == 12'h118 |=> (REG_RDATA & 32'hfffffe00) == 0)
		else $error("control reserved bits set");
	chk_unmapped_zero: assert property (
		REG_RD && REG_ADDR > 12'h12b |=> REG_RDATA == 32'h0)
		else $error("unmapped read not zero");
	chk_report_cause: assert property (
		!ev |=> !CORR_REPORT) else $error("report without event");
	chk_hot_quiet: assert property (
		HOT_RST |=> !CORR_REPORT && !CORR_PENDING)
		else $error("report outputs kept over hot reset");
	chk_gen_on: assert property (
		cw && REG_WDATA[6] ##1 !cw |-> ##[0:1] E2E_CRC_GEN_EN)
		else $error("generation enable not set");
	chk_check_off: assert property (
		cw && !REG_WDATA[8] ##1 !cw |-> ##[0:1] !E2E_CRC_CHECK_EN)
		else $error("check enable not cleared");
endmodule
bind aecr_top aecr_monitor i_mon (.*);

// File: sim/aecr_root_model.sv
// Root complex model counting correctable error reports
`timescale 1ns/1ns
module aecr_root_model (
	input wire clk,
	input wire rst,
	input wire report,
	output int count
);
	always @(posedge clk) begin
		if (rst) begin
			count <= 0;
		end else if (report) begin
			count <= count + 1;
		end
	end
endmodule

// File: sim/tb.sv
// Self-checking bench for the correctable error registers
`timescale 1ns/1ns
module tb;
	logic clk, rst, hot, wr, rd, lock, urep, lk, c5, c7, ge, ce, rel;
	logic [11:0] addr;
	logic [31:0] wdata, d;
	logic [5:0] ev;
	logic [4:0] idx, ptr;
	logic [127:0] hdr, hl;
	wire [31:0] rdata;
	wire rep, pend, gen_en, chk_en;
	int cnt, num_errors, n_tests, c, i;
	integer seed;
	int bt[6] = '{0, 6, 7, 8, 12, 13};
	aecr_top i_dut (.REF_CLK(clk), .RST(rst), .HOT_RST(hot),
		.REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd),
		.REG_RDATA(rdata), .REG_LOCK(lock), .RECEIVER_FAULT(ev[0]),
		.CORRUPT_PACKET_FLAG(ev[1]), .CORRUPT_LINK_PACKET_FLAG(ev[2]),
		.REPLAY_COUNT_WRAP(ev[3]), .REPLAY_TIMER_EXPIRY(ev[4]),
		.ADVISORY_NONFATAL(ev[5]), .UNCORR_REPORT(urep), .UNCORR_INDEX(idx),
		.UNCORR_HEADER(hdr), .UNCORR_RELEASE(rel), .CORR_REPORT(rep),
		.CORR_PENDING(pend), .E2E_CRC_GEN_EN(gen_en),
		.E2E_CRC_CHECK_EN(chk_en));
	aecr_root_model i_root (.clk(clk), .rst(rst), .report(rep), .count(cnt));
	function [31:0] ctl_exp();
		ctl_exp = {23'h0, ce, c7, ge, c5, ptr};
	endfunction
	task chk(input [31:0] s, input [31:0] e, input string n);
		n_tests++;
		if (s !== e) begin
			num_errors++;
			$display("MISMATCH %s exp %h got %h", n, e, s);
		end
	endtask
	task final_report;
		if (num_errors == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	task wreg(input [11:0] a, input [31:0] v);
		@(posedge clk);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task rreg(input [11:0] a, input [31:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk(rdata, e, "read data");
	endtask
	task pulse(input [5:0] v);
		@(posedge clk);
		ev <= v;
		@(posedge clk);
		ev <= 6'h0;
	endtask
	task uncorr(input [4:0] x, input [127:0] v);
		@(posedge clk);
		urep <= 1'b1;
		idx <= x;
		hdr <= v;
		@(posedge clk);
		urep <= 1'b0;
	endtask
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	initial begin
		tick(100000);
		num_errors++;
		final_report;
	end
	initial begin
		seed = 32'he7b1;
		{rst, hot, wr, rd, lock, urep, c5, c7, ge, ce} = 10'h20c;
		{addr, wdata, ev, idx, hdr, ptr, rel} = 0;
		tick(4);
		rst <= 1'b0;
		rreg(12'h110, 32'h0);
		rreg(12'h114, 32'h2000);
		rreg(12'h118, ctl_exp());
		rreg(12'h11c, 32'h0);
		rreg(12'h200, 32'h0);
		for (i = 0; i < 6; i++) begin
			c = cnt;
			pulse(6'h1 << i);
			tick(2);
			chk(cnt, c + (i != 5), "reports");
			chk(pend, i != 5, "pending");
			rreg(12'h110, 32'h1 << bt[i]);
			wreg(12'h110, 32'h0);
			rreg(12'h110, 32'h1 << bt[i]);
			wreg(12'h110, 32'h1 << bt[i]);
			rreg(12'h110, 32'h0);
			chk(pend, 32'h0, "pending cleared");
		end
		wreg(12'h114, 32'hffffffff);
		rreg(12'h114, 32'h31c1);
		c = cnt;
		pulse(6'h3f);
		tick(2);
		chk(cnt, c, "masked reports");
		chk(pend, 32'h0, "masked pending");
		rreg(12'h110, 32'h31c1);
		@(posedge clk);
		ev <= 6'h1;
		wdata <= 32'hffffffff;
		wr <= 1'b1;
		@(posedge clk);
		ev <= 6'h0;
		wr <= 1'b0;
		rreg(12'h110, 32'h1);
		wreg(12'h110, 32'hffffffff);
		wreg(12'h114, 32'h0);
		for (i = 0; i < 24; i++) begin
			d = $random(seed);
			lk = $random(seed);
			@(posedge clk);
			lock <= lk;
			wreg(12'h118, d);
			if (!lk) begin
				c5 = d[5];
				c7 = d[7];
			end
			ge = d[6];
			ce = d[8];
			rreg(12'h118, ctl_exp());
			chk(gen_en, ge, "gen enable");
			chk(chk_en, ce, "check enable");
		end
		@(posedge clk);
		lock <= 1'b0;
		ptr = $random(seed);
		hl = {$random(seed), $random(seed), $random(seed), $random(seed)};
		uncorr(ptr, hl);
		uncorr(~ptr, ~hl);
		rreg(12'h118, ctl_exp());
		for (i = 0; i < 4; i++)
			rreg(12'(12'h11c + 4 * i), hl[32 * i +: 32]);
		@(posedge clk);
		rel <= 1'b1;
		@(posedge clk);
		rel <= 1'b0;
		uncorr(~ptr, ~hl);
		ptr = ~ptr;
		hl = ~hl;
		rreg(12'h118, ctl_exp());
		rreg(12'h11c, hl[31:0]);
		pulse(6'h2);
		@(posedge clk);
		hot <= 1'b1;
		@(posedge clk);
		hot <= 1'b0;
		c5 = 1'b1;
		c7 = 1'b1;
		rreg(12'h118, ctl_exp());
		rreg(12'h110, 32'h40);
		chk(pend, 32'h1, "pending after hot reset");
		rreg(12'h120, hl[63:32]);
		@(posedge clk);
		rst <= 1'b1;
		tick(2);
		rst <= 1'b0;
		rreg(12'h118, 32'ha0);
		rreg(12'h110, 32'h0);
		final_report;
	end
endmodule
